// ---- clock_ctrl.sv ----
/*
 Clock switch, clock monitor watchdog and glitch-free system clock prescaler,
 with a classic Wishbone slave for its registers.
 Assumes oscillator tick levels arrive asynchronously and are synchronised here;
 fuse and trim straps are stable while rst_i is high.
*/
`include "clock_ctrl_defines.svh"

// How it works
// R1: Only one external source enabled at once
// R2: Async timer shares external enable lines
// R3: Software and hardware reload are exclusive
// R4: Auto reload command overrides watchdog enable
// R5: Auto reload mode gives reset, never interrupt
// R6: Period select scales watchdog in every mode
// R7: Only reset leaves auto mode; flag records
// R8: Monitoring needs four system clocks per tick
// R9: Hardware reloads watchdog after one command
// R10: Software arms auto reload before switching
// R11: Monitoring assumes internal reset clock source
// R12: Command codes one, two, three, four, five, six
// R13: Software writes change enable, then command
// R14: Recover writes current source code back
// R15: Select register: start-up 5:4, code 3:0
// R16: Software enables, waits, switches, recovers, disables
// R17: One divided enable for CPU, IO, ADC, flash
// R18: Prescale change without glitch or faster clock
// R19: New prescale active after old plus new
// R20: Prescaler count state is not readable
// R21: Change enable lasts four cycles, not extended
// R22: Ready clears on request, sets at limit
// R23: Code seven drives clock out; 1xxx none
// R24: Prescale codes up to eight; others reserved
// R25: Disabling the running system source is ignored
module clock_ctrl
   import clock_ctrl_pkg::*;
#(
   parameter int unsigned WD_BASE_TICKS = 2048
)
(
   // Clock and resets
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic por_i,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Straps caught at reset
   input wire logic [6:0] fuse_sel_i,
   input wire logic [7:0] trim_cal_i,
   // Oscillator activity and async timer
   input wire logic [4:0] osc_tick_i,
   input wire logic wd_osc_tick_i,
   input wire logic [1:0] tmr_req_i,
   // Clock control
   output logic [4:0] src_en_o,
   output logic [3:0] sys_code_o,
   output clk_en_t clk_en_o,
   output logic clk_out_en_o,
   output logic [7:0] trim_o,
   output logic wd_reset_o,
   output logic wd_irq_o
);

   state_t q;
   state_t d;
   logic [4:0] tk;
   logic wtk;
   logic wr;
   logic cmd_go;
   logic cce_start;
   logic [2:0] s_sel;
   logic [2:0] s_cur;

   function automatic logic [2:0] src_of(input logic [3:0] c);
      if (c[3])
         src_of = `SRC_XTAL;
      else
         case (c[2:0])
            3'h0, 3'h1: src_of = `SRC_EXT;
            3'h3: src_of = `SRC_WD;
            3'h6, 3'h7: src_of = `SRC_LF;
            default: src_of = `SRC_RC;
         endcase
   endfunction

   // External enables refused while another external runs the system
   function automatic logic [4:0] en_src(input logic [4:0] en, input logic [2:0] s,
                                         input logic [2:0] cur);
      logic [4:0] r;
      r = en;
      if (s < `SRC_EXT)
         r[s] = 1'b1;
      else if (cur < `SRC_EXT || cur == s)
      begin
         r[4:2] = 3'h0; // [R1]
         r[s] = 1'b1;
      end
      en_src = r;
   endfunction

   function automatic logic [11:0] osc_lim(input logic [1:0] sut);
      case (sut)
         2'h0: osc_lim = `SUT_LIM0;
         2'h1: osc_lim = `SUT_LIM1;
         2'h2: osc_lim = `SUT_LIM2;
         default: osc_lim = `SUT_LIM3;
      endcase
   endfunction

   function automatic logic [7:0] div_mask(input logic [3:0] p);
      logic [8:0] m;
      m = (9'h001 << p) - 9'h001;
      div_mask = m[7:0];
   endfunction

   function automatic logic [20:0] wd_lim(input logic [3:0] p);
      logic [3:0] e;
      e = (p > `WD_PSEL_MAX) ? `WD_PSEL_MAX : p;
      wd_lim = 21'(WD_BASE_TICKS) << e;
   endfunction

   always_comb
   begin
      d = q;
      d.tk_s1 = osc_tick_i;
      d.tk_s2 = q.tk_s1;
      d.tk_s3 = q.tk_s2;
      d.wtk_s1 = wd_osc_tick_i;
      d.wtk_s2 = q.wtk_s1;
      d.wtk_s3 = q.wtk_s2;
      tk = q.tk_s2 & ~q.tk_s3;
      wtk = q.wtk_s2 & ~q.wtk_s3;
      s_sel = src_of(q.sel[3:0]);
      s_cur = src_of(q.sys_code);
      // Access takes effect on the edge where the master sees ack
      wr = cyc_i & stb_i & we_i & q.ack & sel_i[0];
      cmd_go = 1'b0;
      cce_start = 1'b0;
      d.ack = cyc_i & stb_i & ~q.ack;
      d.wd_rst = 1'b0;
      d.wd_irq = 1'b0;
      if (adr_i == `OFF_CMD)
         d.rdat = {q.cce_cnt != 3'h0, 2'h0, q.rdy, q.cmd};
      else if (adr_i == `OFF_SEL)
         d.rdat = {1'b0, q.sel};
      else if (adr_i == `OFF_PRE)
         d.rdat = {q.pce_cnt != 3'h0, 3'h0, q.ps}; // [R20]
      else if (adr_i == `OFF_TRIM)
         d.rdat = q.trim;
      else if (adr_i == `OFF_WDT)
         d.rdat = {2'h0, q.wdc};
      else if (adr_i == `OFF_RSTC)
         d.rdat = 8'(q.watchdog_reset_flag) << `WATCHDOG_RESET_FLAG_BIT;
      else
         d.rdat = 8'h00;
      if (q.cce_cnt != 3'h0)
         d.cce_cnt = q.cce_cnt - 3'h1;
      if (q.pce_cnt != 3'h0)
         d.pce_cnt = q.pce_cnt - 3'h1;
      // Oscillation counter on the selected source
      if (q.cnt_run && tk[s_sel])
      begin
         d.osc_cnt = q.osc_cnt + 12'h001;
         if (d.osc_cnt >= osc_lim(q.sel[5:4]))
         begin
            d.rdy = 1'b1; // [R22]
            d.cnt_run = 1'b0;
         end
      end
      // Watchdog control bits steer the mode unless auto reload holds it
      if (wr && adr_i == `OFF_WDT)
         d.wdc = dat_i[5:0];
      if (q.wd_mode != WDM_AUTO) // [R7]
         d.wd_mode = (d.wdc[`WD_EN_BIT] || d.wdc[`WD_IE_BIT]) ? WDM_SOFT : WDM_OFF;
      // Command register with its change-enable window
      if (wr && adr_i == `OFF_CMD)
      begin
         if (dat_i[7:0] == `CHG_ENABLE_ONLY)
         begin
            if (q.cce_cnt == 3'h0)
            begin
               cce_start = 1'b1;
               d.cce_cnt = `CHG_WIN; // [R21]
            end
         end
         else if (q.cce_cnt != 3'h0 && !dat_i[`CCE_BIT])
         begin
            cmd_go = 1'b1;
            d.cce_cnt = 3'h0; // [R21]
            d.cmd = dat_i[3:0];
         end
      end
      if (cmd_go)
         case (dat_i[3:0]) // [R12] [R23]
            `CMD_DISABLE:
               if (s_sel != s_cur)
                  d.src_en[s_sel] = 1'b0; // [R25]
            `CMD_ENABLE:
            begin
               d.src_en = en_src(q.src_en, s_sel, s_cur); // [R1]
               d.rdy = 1'b0; // [R22]
               d.cnt_run = 1'b1;
               d.osc_cnt = 12'h000;
            end
            `CMD_REQ:
            begin
               d.rdy = 1'b0; // [R22]
               d.cnt_run = 1'b1;
               d.osc_cnt = 12'h000;
            end
            `CMD_SWITCH:
               if (q.src_en[s_sel] && q.rdy)
                  d.sys_code = q.sel[3:0];
            `CMD_RECOVER: d.sel[3:0] = q.sys_code; // [R14]
            `CMD_ARL: d.wd_mode = WDM_AUTO; // [R4]
            `CMD_COUT: d.cout = q.sel[`COUT_BIT];
            default: ;
         endcase
      if (wr && adr_i == `OFF_SEL)
         d.sel = dat_i[6:0]; // [R15]
      // Async timer requests go through the same enable lines
      if (tmr_req_i[0])
         d.src_en = en_src(d.src_en, `SRC_EXT, s_cur); // [R2]
      if (tmr_req_i[1])
         d.src_en = en_src(d.src_en, `SRC_LF, s_cur); // [R2]
      if (wr && adr_i == `OFF_TRIM)
         d.trim = dat_i[7:0];
      // New ratio starts only at the end of an old period
      d.div = q.div + 8'h01;
      d.div_tick = 1'b0;
      if ((q.div & div_mask(q.ps)) == div_mask(q.ps))
      begin
         d.div_tick = 1'b1; // [R17]
         if (q.ps_pend)
         begin
            d.ps = q.ps_new; // [R18] [R19]
            d.ps_pend = 1'b0;
            d.div = 8'h00;
         end
      end
      // Prescaler register after the apply, so a late write stays pending
      if (wr && adr_i == `OFF_PRE)
      begin
         if (dat_i[7:0] == `CHG_ENABLE_ONLY)
         begin
            if (q.pce_cnt == 3'h0)
               d.pce_cnt = `CHG_WIN;
         end
         else if (q.pce_cnt != 3'h0 && !dat_i[`CCE_BIT])
         begin
            d.pce_cnt = 3'h0;
            if (dat_i[3:0] <= `PRE_MAX) // [R24]
            begin
               d.ps_new = dat_i[3:0];
               d.ps_pend = 1'b1;
            end
         end
      end
      // Watchdog
      if (q.gap != `MON_MIN)
         d.gap = q.gap + 3'h1;
      if (wtk)
         d.gap = 3'h0;
      case (q.wd_mode)
         WDM_OFF: d.wd_cnt = 21'h0;
         WDM_SOFT:
         begin
            if (wr && adr_i == `OFF_WDT && dat_i[`WD_RLD_BIT])
               d.wd_cnt = 21'h0; // [R3]
            else if (wtk)
            begin
               d.wd_cnt = q.wd_cnt + 21'h1;
               if (d.wd_cnt >= wd_lim(q.wdc[3:0])) // [R6]
               begin
                  d.wd_cnt = 21'h0;
                  d.wd_irq = q.wdc[`WD_IE_BIT];
                  d.wd_rst = ~q.wdc[`WD_IE_BIT];
               end
            end
         end
         WDM_AUTO:
            if (wtk)
            begin
               // A tick only reloads if enough system clocks ran since the last
               if (q.gap >= `MON_MIN)
                  d.wd_cnt = 21'h0; // [R8] [R9]
               else
               begin
                  d.wd_cnt = q.wd_cnt + 21'h1;
                  if (d.wd_cnt >= wd_lim(q.wdc[3:0])) // [R6]
                  begin
                     d.wd_cnt = 21'h0;
                     d.wd_rst = 1'b1; // [R5]
                  end
               end
            end
         default: d.wd_cnt = 21'h0;
      endcase
      if (wr && adr_i == `OFF_RSTC && !dat_i[`WATCHDOG_RESET_FLAG_BIT])
         d.watchdog_reset_flag = 1'b0;
      if (q.wd_rst)
         d.watchdog_reset_flag = 1'b1; // [R7]
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         q <= '0;
         q.sel <= fuse_sel_i;
         q.sys_code <= fuse_sel_i[3:0];
         q.src_en <= 5'h01 << src_of(fuse_sel_i[3:0]);
         q.cout <= fuse_sel_i[`COUT_BIT];
         q.ps <= `PRE_RESET;
         q.ps_new <= `PRE_RESET;
         q.trim <= trim_cal_i;
         q.wd_mode <= WDM_OFF; // [R7]
         q.watchdog_reset_flag <= ~por_i & (q.watchdog_reset_flag | q.wd_rst); // [R7]
      end
      else
         q <= d;
   end

   assign dat_o = {24'h000000, q.rdat};
   assign ack_o = q.ack;
   assign src_en_o = q.src_en;
   assign sys_code_o = q.sys_code;
   assign clk_en_o = '{q.div_tick, q.div_tick, q.div_tick, q.div_tick};
   assign clk_out_en_o = q.cout;
   assign trim_o = q.trim;
   assign wd_reset_o = q.wd_rst;
   assign wd_irq_o = q.wd_irq;

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   one_external_a: assert property ($onehot0(q.src_en[4:2])) // [R1]
      else $error("two external sources enabled");
   timer_share_a: assert property (tmr_req_i[0] && s_cur < `SRC_EXT |=> q.src_en[2]) // [R2]
      else $error("timer request did not enable external clock");
   soft_reload_off_a: assert property ( // [R3]
      q.wd_mode == WDM_AUTO && wr && adr_i == `OFF_WDT && !wtk |=> $stable(q.wd_cnt))
      else $error("software reload acted in auto mode");
   arl_priority_a: assert property (cmd_go && dat_i[3:0] == `CMD_ARL |=> q.wd_mode == WDM_AUTO) // [R4]
      else $error("auto reload command not taken");
   auto_no_irq_a: assert property (q.wd_mode == WDM_AUTO |-> ##1 !q.wd_irq) // [R5]
      else $error("interrupt in auto reload mode");
   auto_sticky_a: assert property (q.wd_mode == WDM_AUTO |=> q.wd_mode == WDM_AUTO) // [R7]
      else $error("auto reload mode left without reset");
   hw_reload_a: assert property ( // [R9]
      q.wd_mode == WDM_AUTO && wtk && q.gap >= `MON_MIN |=> q.wd_cnt == 21'h0 && !q.wd_rst)
      else $error("hardware reload missing");
   recover_code_a: assert property ( // [R14]
      cmd_go && dat_i[3:0] == `CMD_RECOVER |=> q.sel[3:0] == $past(q.sys_code))
      else $error("recover did not return current source");
   prescale_apply_a: assert property ( // [R19]
      q.ps_pend && (q.div & div_mask(q.ps)) == div_mask(q.ps)
      |=> q.ps == $past(q.ps_new) && q.div == 8'h00 && !q.ps_pend)
      else $error("prescale change not applied at period end");
   change_window_a: assert property ( // [R21]
      cce_start |=> (q.cce_cnt != 3'h0) [*3] ##2 (q.cce_cnt == 3'h0))
      else $error("change enable window wrong length");
   ready_clear_a: assert property ( // [R22]
      cmd_go && (dat_i[3:0] == `CMD_REQ || dat_i[3:0] == `CMD_ENABLE) |=> !q.rdy)
      else $error("ready not cleared by request");
   sys_alive_a: assert property (q.src_en[s_cur]) // [R25]
      else $error("running system source disabled");
endmodule

// ---- clock_ctrl_defines.svh ----
/*
 Offsets, field positions, reset values and counts of the clock controller.
 Assumes inclusion by bare name from the design module and the bench.
*/
`ifndef CLOCK_CTRL_DEFINES_SVH
`define CLOCK_CTRL_DEFINES_SVH
// Register byte offsets
`define OFF_CMD 8'h00
`define OFF_SEL 8'h04
`define OFF_PRE 8'h08
`define OFF_TRIM 8'h0C
`define OFF_WDT 8'h10
`define OFF_RSTC 8'h14
// Field positions
`define CCE_BIT 7
`define RDY_BIT 4
`define COUT_BIT 6
`define WD_RLD_BIT 7
`define WD_IE_BIT 5
`define WD_EN_BIT 4
`define WATCHDOG_RESET_FLAG_BIT 3
// Command codes
`define CMD_DISABLE 4'h1
`define CMD_ENABLE 4'h2
`define CMD_REQ 4'h3
`define CMD_SWITCH 4'h4
`define CMD_RECOVER 4'h5
`define CMD_ARL 4'h6
`define CMD_COUT 4'h7
// Clock source indices
`define SRC_RC 3'h0
`define SRC_WD 3'h1
`define SRC_EXT 3'h2
`define SRC_LF 3'h3
`define SRC_XTAL 3'h4
// Counts and reset values
`define CHG_ENABLE_ONLY 8'h80
`define CHG_WIN 3'h4
`define PRE_RESET 4'h3
`define PRE_MAX 4'h8
`define WD_PSEL_MAX 4'h9
`define MON_MIN 3'h4
`define SUT_LIM0 12'h010
`define SUT_LIM1 12'h040
`define SUT_LIM2 12'h100
`define SUT_LIM3 12'h400
`endif

// ---- clock_ctrl_pkg.sv ----
/*
 Types of the clock controller: mode enum, clock enable group, state record.
 Assumes clock_ctrl_defines.svh is on the include path.
*/
package clock_ctrl_pkg;
   typedef enum logic [1:0] {WDM_OFF, WDM_SOFT, WDM_AUTO} wd_mode_t;

   typedef struct packed {
      logic cpu;
      logic io;
      logic adc;
      logic flash;
   } clk_en_t;

   typedef struct packed {
      logic ack;
      logic [7:0] rdat;
      logic [2:0] cce_cnt;
      logic [3:0] cmd;
      logic rdy;
      logic [6:0] sel;
      logic [3:0] sys_code;
      logic [4:0] src_en;
      logic cout;
      logic cnt_run;
      logic [11:0] osc_cnt;
      logic [2:0] pce_cnt;
      logic [3:0] ps;
      logic [3:0] ps_new;
      logic ps_pend;
      logic [7:0] div;
      logic div_tick;
      logic [7:0] trim;
      logic [5:0] wdc;
      wd_mode_t wd_mode;
      logic [20:0] wd_cnt;
      logic [2:0] gap;
      logic watchdog_reset_flag;
      logic wd_rst;
      logic wd_irq;
      logic [4:0] tk_s1;
      logic [4:0] tk_s2;
      logic [4:0] tk_s3;
      logic wtk_s1;
      logic wtk_s2;
      logic wtk_s3;
   } state_t;
endpackage

// ---- clock_switch_monitor_prescaler_bench.sv ----
/*
 Self-checking bench of the clock controller: register bus, commands, source
 enables, prescaler pulse spacing and watchdog modes.
 Assumes the package and the defines header are compiled first.
*/
`include "clock_ctrl_defines.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
   $display("MISMATCH %s exp=%h got=%h", nm, e, g); end end
module clock_switch_monitor_prescaler_bench import clock_ctrl_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0, rst_i = 1'b1, por_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [7:0] adr_i = 8'h00, trim_cal_i = 8'h5A, trim_o;
   logic [3:0] sel_i = 4'hF, sys_code_o;
   logic [31:0] dat_i = 32'h0, dat_o, mon_e;
   logic ack_o, clk_out_en_o, wd_reset_o, wd_irq_o;
   // Internal RC source at reset, so monitoring is meaningful
   logic [6:0] fuse_sel_i = 7'h02;
   logic [4:0] osc_tick_i = 5'h00, src_en_o;
   logic wd_osc_tick_i = 1'b0, run_q = 1'b0;
   logic [1:0] tmr_req_i = 2'h0;
   clk_en_t clk_en_o;
   logic [31:0] exp_q[$];
   int n_fail = 0, cmp_count = 0, n_rst = 0, n_irq = 0, seed = 32'hDCF4;

   always #5 clk_i = ~clk_i;

   clock_ctrl #(.WD_BASE_TICKS(4)) u_clock_ctrl (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i),
      .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
      .dat_o(dat_o), .ack_o(ack_o), .fuse_sel_i(fuse_sel_i), .trim_cal_i(trim_cal_i),
      .osc_tick_i(osc_tick_i), .wd_osc_tick_i(wd_osc_tick_i), .tmr_req_i(tmr_req_i),
      .src_en_o(src_en_o), .sys_code_o(sys_code_o), .clk_en_o(clk_en_o),
      .clk_out_en_o(clk_out_en_o), .trim_o(trim_o), .wd_reset_o(wd_reset_o),
      .wd_irq_o(wd_irq_o));

   // Crystal keeps running once proven, so switching has edges to work with
   always @(posedge clk_i)
      if (run_q)
         osc_tick_i[4] <= ~osc_tick_i[4];

   always @(posedge clk_i)
   begin
      if (wd_reset_o === 1'b1)
         n_rst++;
      if (wd_irq_o === 1'b1)
         n_irq++;
      if (ack_o === 1'b1 && cyc_i && !we_i)
      begin
         mon_e = (exp_q.size() != 0) ? exp_q.pop_front() : 32'hDEADBEEF;
         `CHK("rd_data", mon_e, dat_o)
      end
   end

   task automatic final_report();
      $display("Checks %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      for (n = 0; n < 20 && ack_o !== 1'b1; n++) @(posedge clk_i);
      if (ack_o !== 1'b1)
      begin
         n_fail++;
         final_report();
      end
      else
      begin
         cyc_i <= 1'b0;
         stb_i <= 1'b0;
         we_i <= 1'b0;
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask

   // Change enable first, then the code while the window is open
   task automatic cmd(input logic [3:0] c);
      wr(`OFF_CMD, 32'h80);
      wr(`OFF_CMD, {28'h0, c});
   endtask

   task automatic gap(output int g);
      int n;
      for (n = 0; n < 600 && clk_en_o.cpu !== 1'b1; n++) @(posedge clk_i);
      @(posedge clk_i);
      for (g = 1; g < 600 && clk_en_o.cpu !== 1'b1; g++) @(posedge clk_i);
      `CHK("en_group", {4{clk_en_o.cpu}}, clk_en_o)
      if (g >= 600)
      begin
         n_fail++;
         final_report();
      end
   endtask

   task automatic rst(input logic p);
      rst_i <= 1'b1;
      por_i <= p;
      idle(6);
      rst_i <= 1'b0;
   endtask

   task automatic wtk(input int n, input int sp);
      repeat (n)
      begin
         wd_osc_tick_i <= 1'b1;
         @(posedge clk_i);
         wd_osc_tick_i <= 1'b0;
         repeat (sp - 1) @(posedge clk_i);
      end
   endtask

   initial
   begin
      int g1, g2, k, pv;
      logic [7:0] t;
      rst(1'b1);
      rd(`OFF_SEL, 32'h02);
      rd(`OFF_PRE, 32'h03);
      rd(`OFF_TRIM, 32'h5A);
      wr(8'h20, 32'hFF);
      rd(8'h20, 32'h0);
      `CHK("src_en", 5'h01, src_en_o)
      tmr_req_i <= 2'h2;
      idle(1);
      tmr_req_i <= 2'h0;
      idle(3);
      `CHK("tmr_lf", 5'h09, src_en_o)
      // Late code and a re-armed window must both be dropped
      wr(`OFF_CMD, 32'h80);
      rd(`OFF_CMD, 32'h80);
      idle(4);
      wr(`OFF_CMD, 32'h05);
      rd(`OFF_CMD, 32'h00);
      wr(`OFF_CMD, 32'h80);
      wr(`OFF_CMD, 32'h80);
      wr(`OFF_CMD, 32'h05);
      rd(`OFF_CMD, 32'h00);
      wr(`OFF_SEL, 32'h3F);
      cmd(`CMD_RECOVER);
      rd(`OFF_SEL, 32'h32);
      rd(`OFF_CMD, 32'h05);
      wr(`OFF_SEL, 32'h42);
      cmd(`CMD_COUT);
      wr(`OFF_SEL, 32'h02);
      cmd(4'hF);
      idle(2);
      `CHK("cout_kept", 1'b1, clk_out_en_o)
      cmd(`CMD_COUT);
      idle(2);
      `CHK("cout_off", 1'b0, clk_out_en_o)
      wr(`OFF_SEL, 32'h08);
      cmd(`CMD_ENABLE);
      idle(2);
      `CHK("one_ext", 5'h11, src_en_o)
      repeat (15)
      begin
         osc_tick_i[4] <= 1'b1;
         idle(2);
         osc_tick_i[4] <= 1'b0;
         idle(2);
      end
      rd(`OFF_CMD, 32'h02);
      osc_tick_i[4] <= 1'b1;
      idle(2);
      osc_tick_i[4] <= 1'b0;
      idle(6);
      rd(`OFF_CMD, 32'h12);
      cmd(`CMD_REQ);
      rd(`OFF_CMD, 32'h03);
      run_q <= 1'b1;
      idle(100);
      rd(`OFF_CMD, 32'h13);
      cmd(`CMD_SWITCH);
      idle(40);
      cmd(`CMD_RECOVER);
      rd(`OFF_SEL, 32'h08);
      `CHK("sys_code", 4'h8, sys_code_o)
      wr(`OFF_SEL, 32'h02);
      cmd(`CMD_DISABLE);
      wr(`OFF_SEL, 32'h08);
      cmd(`CMD_DISABLE);
      wr(`OFF_SEL, 32'h00);
      cmd(`CMD_ENABLE);
      idle(2);
      `CHK("src_final", 5'h10, src_en_o)
      pv = 3;
      for (int c = 9; c >= 0; c--)
      begin
         wr(`OFF_PRE, 32'h80);
         wr(`OFF_PRE, 32'(c));
         k = (c > 8) ? pv : c;
         gap(g1);
         gap(g2);
         `CHK("gap1", 1'b1, g1 >= (1 << (k < pv ? k : pv)) && g1 <= (1 << (k > pv ? k : pv)))
         `CHK("gap2", 1 << k, g2)
         rd(`OFF_PRE, 32'(k));
         pv = k;
      end
      repeat (3)
      begin
         t = 8'($random(seed));
         wr(`OFF_TRIM, {24'h0, t});
         rd(`OFF_TRIM, {24'h0, t});
         `CHK("trim_o", t, trim_o)
      end
      wr(`OFF_WDT, 32'h31);
      wtk(7, 2);
      idle(6);
      `CHK("irq_early", 0, n_irq)
      wtk(3, 2);
      idle(6);
      `CHK("irq_soft", 1'b1, n_irq > 0)
      cmd(`CMD_ARL);
      wr(`OFF_WDT, 32'h20);
      // Monitor armed before any further switch request
      wr(`OFF_SEL, 32'h08);
      cmd(`CMD_SWITCH);
      `CHK("sys_kept", 4'h8, sys_code_o)
      k = n_irq;
      wtk(12, 8);
      `CHK("auto_slow", 0, n_rst)
      wtk(8, 2);
      idle(6);
      `CHK("auto_fast", 1'b1, n_rst > 0)
      `CHK("auto_no_irq", k, n_irq)
      rst(1'b0);
      rd(`OFF_RSTC, 32'h08);
      k = n_rst;
      wtk(8, 2);
      idle(6);
      `CHK("auto_left", k, n_rst)
      rst(1'b1);
      rd(`OFF_RSTC, 32'h00);
      idle(4);
      final_report();
   end
endmodule
